// ---- rtl/spltc_pkg.sv ----
// Shared constants for the pump, lock and test-output control block
package spltc_pkg;
  localparam int MAIN_FACTOR_W = 8;
  localparam int PROP_ACCEL_W  = 2;
  localparam int INTEG_ACCEL_W = 4;
  localparam int ACCUM_W       = 3;
  localparam int CODE_W        = 24;
  // Pump magnitude divisors, as shifts
  localparam int MAIN_DIV_SHIFT = 5;
  localparam int COMP_DIV_SHIFT = 7;
  // Compensation window around the reference pulse, in reference cycles
  localparam int COMP_LEAD_CYC  = 1;
  localparam int COMP_TRAIL_CYC = 1;
  localparam logic [1:0] TEST_LOCK = 2'h0;
  localparam logic [1:0] TEST_REF  = 2'h1;
  localparam logic [1:0] TEST_AUX  = 2'h2;
  localparam logic [1:0] TEST_MAIN = 2'h3;
  localparam logic [1:0] TEST_RST  = 2'h0;
  localparam logic       LOCK_RST  = 1'b0;
  typedef enum logic [1:0]
  {
    SPL_NORMAL  = 2'b01,
    SPL_SPEEDUP = 2'b10
  } spltc_mode_t;
endpackage

// ---- rtl/spltc_scale.sv ----
// Pump code scaler: base times mode multiplier
`timescale 1ns/1ps
module spltc_scale
(
  input  wire logic [17:0] base,
  input  wire logic [4:0]  mult,
  output logic      [23:0] scaled
);
  always_comb
  begin
    scaled = 24'(base) * 24'(mult);
  end
endmodule

// ---- rtl/spltc_sync2.sv ----
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module spltc_sync2
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic rstVal,
  input  wire logic din,
  output logic      dout
);
  logic stage1_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stage1_r <= rstVal;
      dout     <= rstVal;
    end
    else
    begin
      stage1_r <= din;
      dout     <= stage1_r;
    end
  end
endmodule

// ---- rtl/spltc_top.sv ----
// Main pump mode, current codes, lock detect and test output mux
`timescale 1ns/1ps
module spltc_top
(
  input  wire logic                                 clk,
  input  wire logic                                 sys_rst,
  input  wire logic                                 aWordLoaded,
  input  wire logic                                 serialStrobe,
  input  wire logic [spltc_pkg::MAIN_FACTOR_W-1:0]  main_pump_factor,
  input  wire logic [spltc_pkg::PROP_ACCEL_W-1:0]   prop_accel_factor,
  input  wire logic [spltc_pkg::INTEG_ACCEL_W-1:0]  integ_accel_factor,
  input  wire logic [7:0]                           main_current_set,
  input  wire logic [7:0]                           comp_current_set,
  input  wire logic [spltc_pkg::ACCUM_W-1:0]        fraction_accum_value,
  input  wire logic                                 refPreTerm,
  input  wire logic                                 refDivPulse,
  input  wire logic                                 main_div_enable,
  input  wire logic                                 aux_div_enable,
  input  wire logic                                 mainPdLocked,
  input  wire logic                                 auxPdLocked,
  input  wire logic                                 eWordLoaded,
  input  wire logic                                 test_sel_hi,
  input  wire logic                                 test_sel_lo,
  input  wire logic                                 auxDivOut,
  input  wire logic                                 mainDivOut,
  input  wire logic                                 testPin,
  input  wire logic                                 prescalerOut,
  output logic                                      mainDivIn,
  output logic                                      speedUp,
  output logic [spltc_pkg::CODE_W-1:0]              proportional_pump_out,
  output logic [spltc_pkg::CODE_W-1:0]              integral_pump_out,
  output logic                                      compEnable,
  output logic [spltc_pkg::ACCUM_W-1:0]             compAccum,
  output logic                                      lockPin
);
  spltc_pkg::spltc_mode_t mode_r;
  logic                   armed_r;
  logic                   strobeSync;
  logic                   testSync;
  logic                   trail_r;
  logic                   eSeen_r;
  logic [1:0]             testSel_r;
  logic [17:0]            mainTerm;
  logic [17:0]            compTerm;
  logic [17:0]            integMain;
  logic [17:0]            integComp;
  logic [4:0]             propMult;
  logic [4:0]             integMult;
  logic [23:0]            propMainS;
  logic [23:0]            propCompS;
  logic [23:0]            integMainS;
  logic [23:0]            integCompS;
  logic                   lockAll;
  logic                   lockMux;

  // Strobe is a pin; test pin too
  spltc_sync2 uStrobe
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rstVal  (1'b0),
    .din     (serialStrobe),
    .dout    (strobeSync)
  );
  spltc_sync2 uTest
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rstVal  (1'b1),
    .din     (testPin),
    .dout    (testSync)
  );

  // Armed once an A word has been loaded
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      armed_r <= 1'b0;
    else if (aWordLoaded)
      armed_r <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mode_r <= spltc_pkg::SPL_NORMAL;
    else if ((armed_r || aWordLoaded) && strobeSync)
      mode_r <= spltc_pkg::SPL_SPEEDUP;
    else
      mode_r <= spltc_pkg::SPL_NORMAL;
  end

  always_comb
  begin
    case (mode_r)
      spltc_pkg::SPL_SPEEDUP: speedUp = 1'b1;
      spltc_pkg::SPL_NORMAL:  speedUp = 1'b0;
      default:                speedUp = 1'b0;
    endcase
  end

  // Compensation window: lead cycle, pulse cycle, trailing cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      trail_r <= 1'b0;
    else
      trail_r <= refDivPulse;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      compEnable <= 1'b0;
    else
      compEnable <= refPreTerm || refDivPulse || trail_r;
  end

  // Accumulator frozen during window to keep pulse area fixed
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      compAccum <= '0;
    else if (refPreTerm && !compEnable)
      compAccum <= fraction_accum_value;
  end

  // Base terms kept in 1/128 units: main*4 equals main/32
  always_comb
  begin
    mainTerm  = 18'(main_pump_factor) * 18'(main_current_set) * 18'h00004;
    compTerm  = 18'(compAccum) * 18'(comp_current_set);
    integMain = mainTerm;
    integComp = 18'(compAccum) * 18'(main_current_set);
    propMult  = speedUp ? 5'((5'h02 << prop_accel_factor) + 5'h01)
                        : 5'h01;
    integMult = 5'h02 << prop_accel_factor;
  end

  spltc_scale uPropMain
  (
    .base   (mainTerm),
    .mult   (propMult),
    .scaled (propMainS)
  );
  spltc_scale uPropComp
  (
    .base   (compTerm),
    .mult   (propMult),
    .scaled (propCompS)
  );
  spltc_scale uIntMain
  (
    .base   (integMain),
    .mult   (integMult),
    .scaled (integMainS)
  );
  spltc_scale uIntComp
  (
    .base   (integComp),
    .mult   (integMult),
    .scaled (integCompS)
  );

  // Outputs in units of 1/128 of the set current
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      proportional_pump_out <= '0;
    else
      proportional_pump_out <= propMainS
        + (compEnable ? propCompS : 24'h000000);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      integral_pump_out <= '0;
    else if (!speedUp)
      integral_pump_out <= '0;
    else
      integral_pump_out <= 24'((integMainS
        + (compEnable ? integCompS : 24'h000000))
        * 24'(integ_accel_factor));
  end

  // Test select; reset value keeps normal lock until an E word arrives
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      testSel_r <= spltc_pkg::TEST_RST;
      eSeen_r   <= 1'b0;
    end
    else if (eWordLoaded)
    begin
      testSel_r <= {test_sel_hi, test_sel_lo};
      eSeen_r   <= 1'b1;
    end
  end

  always_comb
  begin
    lockAll = (mainPdLocked || !main_div_enable)
           && (auxPdLocked || !aux_div_enable);
    case (eSeen_r ? testSel_r : spltc_pkg::TEST_LOCK)
      spltc_pkg::TEST_LOCK: lockMux = lockAll;
      spltc_pkg::TEST_REF:  lockMux = refDivPulse;
      spltc_pkg::TEST_AUX:  lockMux = auxDivOut;
      spltc_pkg::TEST_MAIN: lockMux = mainDivOut;
      default:              lockMux = lockAll;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lockPin <= spltc_pkg::LOCK_RST;
    else
      lockPin <= lockMux;
  end

  // Test input high in service inverts the prescaler; edge count unchanged
  assign mainDivIn = testSync ^ prescalerOut;

  sequence s_refPulse;
    refDivPulse;
  endsequence

  chk_window_trail: assert property (@(posedge clk) disable iff (sys_rst)
    s_refPulse |-> ##1 compEnable ##1 compEnable)
    else $error("comp window not held after pulse");
  chk_window_off: assert property (@(posedge clk) disable iff (sys_rst)
    !refPreTerm && !refDivPulse && !trail_r |=> !compEnable)
    else $error("comp window on without cause");
  chk_mode_speed: assert property (@(posedge clk) disable iff (sys_rst)
    !strobeSync |=> !speedUp)
    else $error("speed-up without strobe");
  chk_integ_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !speedUp |=> integral_pump_out == 24'h000000)
    else $error("integral pump active in normal mode");
  chk_prop_normal: assert property (@(posedge clk) disable iff (sys_rst)
    !speedUp && !compEnable |=> proportional_pump_out
      == $past(24'(mainTerm)))
    else $error("normal proportional code wrong");
  chk_lock_both: assert property (@(posedge clk) disable iff (sys_rst)
    !eSeen_r && !lockAll |=> !lockPin)
    else $error("lock shown with detector unlocked");
  chk_lock_dis: assert property (@(posedge clk) disable iff (sys_rst)
    !eSeen_r && !main_div_enable && !aux_div_enable |=> lockPin)
    else $error("disabled dividers not locked");
  chk_ref_route: assert property (@(posedge clk) disable iff (sys_rst)
    eSeen_r && testSel_r == spltc_pkg::TEST_REF |=>
      lockPin == $past(refDivPulse))
    else $error("reference pulse not routed");
  chk_main_route: assert property (@(posedge clk) disable iff (sys_rst)
    eSeen_r && testSel_r == spltc_pkg::TEST_MAIN |=>
      lockPin == $past(mainDivOut))
    else $error("main divider not routed");

  // Accumulator taken once, in the lead cycle only
  sequence s_leadSample;
    refPreTerm && !compEnable;
  endsequence
  chk_accum_take: assert property (@(posedge clk) disable iff (sys_rst)
    s_leadSample |=> compAccum == $past(fraction_accum_value))
    else $error("accumulator not sampled at window lead");
  chk_accum_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !(refPreTerm && !compEnable) |=> $stable(compAccum))
    else $error("accumulator changed outside lead cycle");
  chk_speed_entry: assert property (@(posedge clk) disable iff (sys_rst)
    armed_r && strobeSync |=> speedUp)
    else $error("strobe high after A word but no speed-up");
  chk_prop_speed: assert property (@(posedge clk) disable iff (sys_rst)
    speedUp && !compEnable |=> proportional_pump_out
      == $past(((24'(mainTerm) << 2'h1) << prop_accel_factor)
      + 24'(mainTerm)))
    else $error("speed-up proportional code wrong");
  chk_lock_route: assert property (@(posedge clk) disable iff (sys_rst)
    eSeen_r && testSel_r == spltc_pkg::TEST_LOCK |=>
      lockPin == $past(lockAll))
    else $error("lock not shown with test bits low");
  chk_lock_unset: assert property (@(posedge clk) disable iff (sys_rst)
    !eSeen_r |=> lockPin == $past(lockAll))
    else $error("lock not shown before any E word");
  chk_aux_route: assert property (@(posedge clk) disable iff (sys_rst)
    eSeen_r && testSel_r == spltc_pkg::TEST_AUX |=>
      lockPin == $past(auxDivOut))
    else $error("auxiliary divider not routed");
endmodule

// ---- tb/spltc_loop_model.sv ----
// Loop filter and VCO stand-in feeding the prescaler and the test pin
`timescale 1ns/1ps
module spltc_loop_model
(
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        forceTestLow,
  input  wire logic [spltc_pkg::CODE_W-1:0] integral_pump_out,
  output logic                             prescalerOut,
  output logic                             testPin
);
  logic [spltc_pkg::CODE_W-1:0] phaseAcc_r;
  // Integral drive speeds the VCO up, so the prescaler edge moves
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      phaseAcc_r <= '0;
    else
      phaseAcc_r <= phaseAcc_r + 24'h400000 + integral_pump_out;
  end
  assign prescalerOut = phaseAcc_r[spltc_pkg::CODE_W-1];
  // Held high while running as a synthesizer
  assign testPin = ~forceTestLow;
endmodule

// ---- tb/synth_pump_lock_test_ctrl_bench.sv ----
// Self-checking bench for the pump, lock and test-output block
`timescale 1ns/1ps
module synth_pump_lock_test_ctrl_bench;
  typedef struct {logic s; logic [7:0] f; logic [1:0] l; logic [3:0] k;
    logic [7:0] m; logic [7:0] c; logic [3:0] lk;} spltc_row_t;
  logic        clk = 1'b0, sys_rst = 1'b1, forceTestLow = 1'b0;
  logic        aWordLoaded = 1'b0, serialStrobe = 1'b0, eWordLoaded = 1'b0;
  logic [7:0]  main_pump_factor = 8'h0, main_current_set = 8'h0;
  logic [7:0]  comp_current_set = 8'h0;
  logic [1:0]  prop_accel_factor = 2'h0;
  logic [3:0]  integ_accel_factor = 4'h0;
  logic [2:0]  fraction_accum_value = 3'h5;
  logic        refPreTerm = 1'b0, refDivPulse = 1'b0, main_div_enable = 1'b1;
  logic        aux_div_enable = 1'b1, mainPdLocked = 1'b1, auxPdLocked = 1'b1;
  logic        test_sel_hi = 1'b0, test_sel_lo = 1'b0;
  logic        auxDivOut = 1'b1, mainDivOut = 1'b1;
  logic        testPin, prescalerOut, mainDivIn, speedUp, compEnable, lockPin;
  logic [23:0] proportional_pump_out, integral_pump_out;
  logic [2:0]  compAccum;
  int          num_errors = 0;
  int          compares = 0;
  spltc_row_t  rows [6] = '{
    '{1'b0, 8'h0A, 2'h0, 4'h0, 8'h14, 8'h06, 4'hF},
    '{1'b0, 8'hFF, 2'h0, 4'h3, 8'hFF, 8'h01, 4'h7},
    '{1'b1, 8'h03, 2'h1, 4'h1, 8'h07, 8'h05, 4'hB},
    '{1'b1, 8'h09, 2'h2, 4'hF, 8'h04, 8'h02, 4'h5},
    '{1'b1, 8'hFF, 2'h0, 4'h7, 8'hFF, 8'h09, 4'h8},
    '{1'b1, 8'h10, 2'h3, 4'h2, 8'h10, 8'h03, 4'hC}};

  always #4 clk = ~clk;

  spltc_top spltc_top_inst (.clk, .sys_rst, .aWordLoaded, .serialStrobe,
    .main_pump_factor, .prop_accel_factor, .integ_accel_factor,
    .main_current_set, .comp_current_set, .fraction_accum_value, .refPreTerm,
    .refDivPulse, .main_div_enable, .aux_div_enable, .mainPdLocked,
    .auxPdLocked, .eWordLoaded, .test_sel_hi, .test_sel_lo, .auxDivOut,
    .mainDivOut, .testPin, .prescalerOut, .mainDivIn, .speedUp,
    .proportional_pump_out, .integral_pump_out, .compEnable, .compAccum,
    .lockPin);
  spltc_loop_model spltc_loop_model_inst (.clk, .sys_rst, .forceTestLow,
    .integral_pump_out, .prescalerOut, .testPin);

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkc(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Codes in 1/128 of a set current, so the main term carries a factor 4
  function automatic logic [23:0] expCode(spltc_row_t r, logic integ,
                                          logic win);
    logic [23:0] m4, sh, cp;
    m4 = 24'(r.f) * 24'(r.m) * 24'h4;
    sh = 24'h1 << (24'(r.l) + 24'h1);
    cp = win ? 24'(fraction_accum_value) * 24'(integ ? r.m : r.c) : 24'h0;
    if (!integ)
      return r.s ? (m4 + cp) * (sh + 24'h1) : m4 + cp;
    return r.s ? (m4 + cp) * sh * 24'(r.k) : 24'h0;
  endfunction
  task automatic srcSet(input int sm, input logic v);
    case (sm)
      0: mainPdLocked <= v;
      1: refDivPulse <= v;
      2: auxDivOut <= v;
      default: mainDivOut <= v;
    endcase
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #40000;
    num_errors++;
    wrap_up;
  end

  initial
  begin
    int sm;
    logic act;
    cyc(8);
    #1;
    chk1(lockPin, 1'b0);
    chkc(proportional_pump_out | integral_pump_out, 24'h0);
    chk1(speedUp | compEnable | (compAccum != 3'h0), 1'b0);
    cyc(1);
    sys_rst <= 1'b0;
    serialStrobe <= 1'b1;
    $display("test reset done");
    cyc(6);
    #1;
    chk1(speedUp, 1'b0);
    chk1(mainDivIn, ~prescalerOut);
    cyc(1);
    forceTestLow <= 1'b1;
    cyc(4);
    #1;
    chk1(mainDivIn, prescalerOut);
    $display("test strobe and test pin done");
    foreach (rows[i])
    begin
      cyc(1);
      main_pump_factor <= rows[i].f;
      prop_accel_factor <= rows[i].l;
      integ_accel_factor <= rows[i].k;
      main_current_set <= rows[i].m;
      comp_current_set <= rows[i].c;
      {mainPdLocked, auxPdLocked} <= rows[i].lk[3:2];
      {main_div_enable, aux_div_enable} <= rows[i].lk[1:0];
      aWordLoaded <= 1'b1;
      cyc(1);
      aWordLoaded <= 1'b0;
      serialStrobe <= rows[i].s;
      cyc(5);
      #1;
      chk1(speedUp, rows[i].s);
      chkc(proportional_pump_out, expCode(rows[i], 1'b0, 1'b0));
      chkc(integral_pump_out, expCode(rows[i], 1'b1, 1'b0));
      chk1(lockPin, (rows[i].lk[3] | ~rows[i].lk[1])
                  & (rows[i].lk[2] | ~rows[i].lk[0]));
    end
    $display("test table done");
    cyc(1);
    refPreTerm <= 1'b1;
    cyc(1);
    refPreTerm <= 1'b0;
    refDivPulse <= 1'b1;
    #1;
    chk1(compEnable, 1'b1);
    chk1(compAccum === fraction_accum_value, 1'b1);
    cyc(1);
    refDivPulse <= 1'b0;
    #1;
    chk1(compEnable, 1'b1);
    cyc(1);
    #1;
    chk1(compEnable, 1'b1);
    chkc(proportional_pump_out, expCode(rows[5], 1'b0, 1'b1));
    chkc(integral_pump_out, expCode(rows[5], 1'b1, 1'b1));
    cyc(1);
    #1;
    chk1(compEnable, 1'b0);
    $display("test compensation window done");
    cyc(1);
    {mainPdLocked, auxPdLocked, main_div_enable, aux_div_enable} <= 4'hF;
    {test_sel_hi, test_sel_lo} <= 2'h3;
    for (int m = 0; m < 5; m++)
    begin
      sm = (m == 0) ? 0 : m - 1;
      act = (sm == 1);
      if (m > 0)
      begin
        cyc(1);
        {test_sel_hi, test_sel_lo} <= 2'(sm);
        eWordLoaded <= 1'b1;
        cyc(1);
        eWordLoaded <= 1'b0;
      end
      cyc(2);
      srcSet(sm, act);
      cyc(1);
      #1;
      chk1(lockPin, act);
      cyc(1);
      srcSet(sm, ~act);
      cyc(1);
      #1;
      chk1(lockPin, ~act);
    end
    $display("test lock pin select done");
    wrap_up;
  end
endmodule
